// File: src/dcf_pkg.sv
// Shared constants and carrier types for the dual-clock word buffer
package dcf_pkg;

  // Buffer geometry
  localparam int DEPTH = 64;
  localparam int WIDTH = 18;
  localparam int PTR_W = 7;
  localparam int OFS_W = 5;

  // Flag thresholds
  localparam logic [PTR_W-1:0] FULL_COUNT = 7'h40;
  localparam logic [PTR_W-1:0] HALF_COUNT = 7'h20;

  // Offset default when programming is skipped
  localparam logic [OFS_W-1:0] OFS_DEFAULT = 5'h08;

  // Pointer reset value
  localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;

  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;

  // Field positions
  localparam int ST_COUNT_LSB = 0;
  localparam int ST_FULL_N = 8;
  localparam int ST_EMPTY_N = 9;
  localparam int ST_HALF = 10;
  localparam int ST_ALMOST = 11;
  localparam int ST_WRITTEN = 12;
  localparam int OFS_EMPTY_LSB = 0;
  localparam int OFS_FULL_LSB = 8;
  localparam int CTRL_FLUSH = 0;

  // Flag group as seen on the pins
  typedef struct packed {
    logic full_n;
    logic empty_n;
    logic half;
    logic almost;
  } dcf_flags_t;

  // Flag values held during and just after reset
  localparam dcf_flags_t FLAGS_RESET = '{full_n: 1'b1, empty_n: 1'b0,
                                         half: 1'b0, almost: 1'b1};

  // APB answer group
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dcf_apb_resp_t;

  // Whole control state of the buffer
  typedef struct packed {
    logic [2:0] ld_sync;
    logic [2:0] ul_sync;
    logic [1:0] pen_sync;
    logic [1:0] dis_sync;
    logic [WIDTH-1:0] d_s1;
    logic [WIDTH-1:0] d_s2;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [OFS_W-1:0] ofs_empty;
    logic [OFS_W-1:0] ofs_full;
    logic written;
    logic prog_cnt;
    dcf_flags_t flags;
    logic rd_oe_n;
    dcf_apb_resp_t apb;
  } dcf_state_t;

endpackage

// File: src/dcf_fifo.sv
// Dual-clock 64x18 word buffer with programmable almost flag
`timescale 1ns/10ps

// Behaviour
// (R01) Store 64 words of 18 bits, in order
// (R02) Load edge writes only while not full
// (R03) Unload edge advances only while not empty
// (R04) Full at 64 words; loads then ignored
// (R05) Full flag low when full
// (R06) Empty flag low when empty
// (R07) Half flag high at 32 or more
// (R08) Almost flag from empty and full offsets
// (R09) Reset clears pointers and sets flags
// (R10) Almost flag high after reset
// (R11) Reset leaves read data undefined
// (R12) System resets the buffer after power-up
// (R13) First word appears without an unload
// (R14) Read data non-inverted, floats when disabled
// (R15) Offsets programmable only before first write
// (R16) Writer lowers program enable while clock low
// (R17) First program edge sets both offsets
// (R18) Second program edge sets full offset
// (R19) Program edges write no word
// (R20) Offsets are unsigned five-bit values
// (R21) Default offsets of eight each
// (R22) Clock-domain crossings are synchronised safely
module dcf_fifo (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load_clock,
  input wire logic unload_clock,
  input wire logic offset_program_enable_n,
  input wire logic output_disable,
  input wire logic [dcf_pkg::WIDTH-1:0] write_data,
  output logic [dcf_pkg::WIDTH-1:0] read_data,
  output logic read_data_oe_n,
  output logic full_n,
  output logic empty_n,
  output logic half_full_flag,
  output logic almost_flag,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Registered state and its next value
  dcf_pkg::dcf_state_t s;
  dcf_pkg::dcf_state_t next_s;

  // Word storage, never reset
  logic [dcf_pkg::WIDTH-1:0] mem [dcf_pkg::DEPTH];

  // Read data register, left unreset on purpose
  logic [dcf_pkg::WIDTH-1:0] rdata;
  logic [dcf_pkg::WIDTH-1:0] next_rdata;

  // Decoded events of this cycle
  logic ld_rise;
  logic ul_rise;
  logic pen_low;
  logic prog_edge;
  logic wr_en;
  logic rd_en;
  logic flush;
  logic apb_done;
  logic [dcf_pkg::PTR_W-1:0] count;

  // Word count between two pointers
  function automatic logic [dcf_pkg::PTR_W-1:0] fill(
    input logic [dcf_pkg::PTR_W-1:0] wp,
    input logic [dcf_pkg::PTR_W-1:0] rp
  );
    fill = dcf_pkg::PTR_W'(wp - rp);
  endfunction

  // Flag values for a given count and offsets
  function automatic dcf_pkg::dcf_flags_t flags_of(
    input logic [dcf_pkg::PTR_W-1:0] cnt,
    input logic [dcf_pkg::OFS_W-1:0] ofs_e,
    input logic [dcf_pkg::OFS_W-1:0] ofs_f
  );
    logic [dcf_pkg::PTR_W-1:0] hi;
    hi = dcf_pkg::PTR_W'(dcf_pkg::FULL_COUNT - {2'b00, ofs_f});
    flags_of.full_n = (cnt != dcf_pkg::FULL_COUNT);
    flags_of.empty_n = (cnt != dcf_pkg::PTR_RESET);
    flags_of.half = (cnt >= dcf_pkg::HALF_COUNT);
    flags_of.almost = (cnt <= {2'b00, ofs_e}) || (cnt >= hi);
  endfunction

  // Event decode from the synchronised pins and the APB bus
  always_comb begin
    // Edges seen on the second stage against a third copy
    ld_rise = s.ld_sync[1] & ~s.ld_sync[2];
    ul_rise = s.ul_sync[1] & ~s.ul_sync[2];
    pen_low = ~s.pen_sync[1];
    count = fill(s.wp, s.rp);
    // (R15) Programming window closes at first write
    prog_edge = ld_rise & pen_low & ~s.written;
    // (R02) Load writes only while not full
    // (R19) Program edges never write
    wr_en = ld_rise & ~prog_edge & (count != dcf_pkg::FULL_COUNT);
    // (R03) Unload moves only while not empty
    rd_en = ul_rise & (count != dcf_pkg::PTR_RESET);
    // Access phase of an APB transfer, read or write, completes here
    apb_done = psel & penable & s.apb.pready;
    flush = apb_done & pwrite & (paddr == dcf_pkg::ADDR_CTRL)
            & pwdata[dcf_pkg::CTRL_FLUSH];
  end

  // Next-state logic for the whole buffer
  always_comb begin
    next_s = s;
    // (R22) Two flops before any logic looks at a pin outside the APB bus
    next_s.ld_sync = {s.ld_sync[1:0], load_clock};
    next_s.ul_sync = {s.ul_sync[1:0], unload_clock};
    next_s.pen_sync = {s.pen_sync[0], offset_program_enable_n};
    next_s.dis_sync = {s.dis_sync[0], output_disable};
    // Data travels with the same latency as the load edge
    next_s.d_s1 = write_data;
    next_s.d_s2 = s.d_s1;

    // (R17) First program edge loads both offsets
    // (R18) A further edge reloads only the full offset
    // (R20) Five-bit unsigned value from bits 4..0
    if (prog_edge) begin
      next_s.ofs_full = s.d_s2[dcf_pkg::OFS_W-1:0];
      if (!s.prog_cnt) begin
        next_s.ofs_empty = s.d_s2[dcf_pkg::OFS_W-1:0];
      end
      next_s.prog_cnt = 1'b1;
    end else if (!pen_low) begin
      // Releasing program enable restarts the two-edge sequence
      next_s.prog_cnt = 1'b0;
    end

    // (R01) Pointers walk the storage in order
    if (wr_en) begin
      next_s.wp = dcf_pkg::PTR_W'(s.wp + 7'h01);
      next_s.written = 1'b1;
    end
    if (rd_en) begin
      next_s.rp = dcf_pkg::PTR_W'(s.rp + 7'h01);
    end

    // Software flush acts like a reset of pointers and offsets
    if (flush) begin
      next_s.wp = dcf_pkg::PTR_RESET;
      next_s.rp = dcf_pkg::PTR_RESET;
      next_s.written = 1'b0;
      next_s.prog_cnt = 1'b0;
      next_s.ofs_empty = dcf_pkg::OFS_DEFAULT;
      next_s.ofs_full = dcf_pkg::OFS_DEFAULT;
    end

    // (R05) (R06) (R07) (R08) Flags follow the new count
    next_s.flags = flags_of(fill(next_s.wp, next_s.rp),
                            next_s.ofs_empty, next_s.ofs_full);

    // (R14) Output enable low while driving read data
    next_s.rd_oe_n = s.dis_sync[1];

    // APB answer one cycle after setup, no wait states beyond
    next_s.apb.pready = psel & ~penable & ~s.apb.pready;
    next_s.apb.pslverr = 1'b0;
    next_s.apb.prdata = 32'h0000_0000;
    if (psel & ~penable & ~s.apb.pready) begin
      case (paddr)
        dcf_pkg::ADDR_STATUS: begin
          next_s.apb.prdata[dcf_pkg::ST_COUNT_LSB +: dcf_pkg::PTR_W] =
            count;
          next_s.apb.prdata[dcf_pkg::ST_FULL_N] = s.flags.full_n;
          next_s.apb.prdata[dcf_pkg::ST_EMPTY_N] = s.flags.empty_n;
          next_s.apb.prdata[dcf_pkg::ST_HALF] = s.flags.half;
          next_s.apb.prdata[dcf_pkg::ST_ALMOST] = s.flags.almost;
          next_s.apb.prdata[dcf_pkg::ST_WRITTEN] = s.written;
        end
        dcf_pkg::ADDR_OFFSET: begin
          next_s.apb.prdata[dcf_pkg::OFS_EMPTY_LSB +: dcf_pkg::OFS_W] =
            s.ofs_empty;
          next_s.apb.prdata[dcf_pkg::OFS_FULL_LSB +: dcf_pkg::OFS_W] =
            s.ofs_full;
        end
        dcf_pkg::ADDR_CTRL: begin
          // Flush bit is a strobe and reads back as zero
          next_s.apb.prdata = 32'h0000_0000;
        end
        default: begin
          // Unmapped address answers with an error
          next_s.apb.pslverr = 1'b1;
        end
      endcase
    end
  end

  // (R13) Read data bypasses a write landing on the read slot
  always_comb begin
    if (wr_en && (s.wp[5:0] == next_s.rp[5:0])) begin
      next_rdata = s.d_s2;
    end else begin
      next_rdata = mem[next_s.rp[5:0]];
    end
  end

  // State register
  // (R09) (R10) (R21) Reset values of pointers, flags, offsets
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.wp <= dcf_pkg::PTR_RESET;
      s.rp <= dcf_pkg::PTR_RESET;
      s.ofs_empty <= dcf_pkg::OFS_DEFAULT;
      s.ofs_full <= dcf_pkg::OFS_DEFAULT;
      s.flags <= dcf_pkg::FLAGS_RESET;
      s.rd_oe_n <= 1'b1;
      s.ld_sync <= 3'h7;
      s.pen_sync <= 2'h3;
      s.dis_sync <= 2'h3;
    end else begin
      s <= next_s;
    end
  end

  // Storage and read data, no reset
  // (R11) Read data keeps whatever the storage holds
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[s.wp[5:0]] <= s.d_s2;
    end
    rdata <= next_rdata;
  end

  // Outputs straight from flops
  assign read_data = rdata;
  assign read_data_oe_n = s.rd_oe_n;
  assign full_n = s.flags.full_n;
  assign empty_n = s.flags.empty_n;
  assign half_full_flag = s.flags.half;
  assign almost_flag = s.flags.almost;
  assign prdata = s.apb.prdata;
  assign pready = s.apb.pready;
  assign pslverr = s.apb.pslverr;

  // Checks on the design's own behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  depth_bound_a: assert property (count <= dcf_pkg::FULL_COUNT) // R04
    else $error("stored count beyond depth");

  full_flag_a: assert property ( // R05
    !full_n == (count == dcf_pkg::FULL_COUNT))
    else $error("full flag disagrees with count");

  empty_flag_a: assert property ( // R06
    !empty_n == (count == dcf_pkg::PTR_RESET))
    else $error("empty flag disagrees with count");

  half_flag_a: assert property ( // R07
    half_full_flag == (count >= dcf_pkg::HALF_COUNT))
    else $error("half flag disagrees with count");

  almost_flag_a: assert property ( // R08
    almost_flag == ((count <= {2'b00, s.ofs_empty}) ||
      (count >= dcf_pkg::PTR_W'(dcf_pkg::FULL_COUNT -
      {2'b00, s.ofs_full}))))
    else $error("almost flag disagrees with offsets");

  full_hold_a: assert property ( // R04
    ld_rise && !full_n && !flush |=> $stable(s.wp))
    else $error("load accepted while full");

  empty_hold_a: assert property ( // R03
    ul_rise && !empty_n && !flush |=> $stable(s.rp))
    else $error("unload moved while empty");

  load_write_a: assert property ( // R02
    wr_en && !flush |=> s.wp == $past(s.wp) + 7'h01 ##1
      mem[$past(s.wp[5:0], 2)] == $past(s.d_s2, 2))
    else $error("accepted word not stored");

  first_prog_a: assert property ( // R17
    prog_edge && !s.prog_cnt && !flush |=>
      s.ofs_empty == $past(s.d_s2[4:0]) &&
      s.ofs_full == $past(s.d_s2[4:0]))
    else $error("first program edge missed offsets");

  second_prog_a: assert property ( // R18
    prog_edge && s.prog_cnt && !flush |=>
      $stable(s.ofs_empty) && s.ofs_full == $past(s.d_s2[4:0]))
    else $error("second program edge touched empty offset");

  prog_nowrite_a: assert property ( // R19
    prog_edge && !flush |=> $stable(s.wp) && !s.written)
    else $error("program edge wrote a word");

  oe_follow_a: assert property ( // R14
    s.dis_sync[1] |=> read_data_oe_n)
    else $error("read data driven while disabled");

  first_word_a: assert property ( // R13
    wr_en && !empty_n && !rd_en && !flush |=> ##1
      empty_n && read_data == $past(s.d_s2, 2))
    else $error("first word not presented");

endmodule

// File: tb/dcf_far_model.sv
// Writer and reader model driving the buffer's strobe pins
`timescale 1ns/10ps
module dcf_far_model (
  input wire logic mclk,
  output logic load_clock,
  output logic unload_clock,
  output logic offset_program_enable_n,
  output logic [dcf_pkg::WIDTH-1:0] write_data
);
  // Strobe phase; the pin sync needs at least three cycles each way
  localparam int PH = 4;

  // default offsets: program enable idles high
  initial begin
    load_clock = 1'b0;
    unload_clock = 1'b0;
    offset_program_enable_n = 1'b1;
    write_data = 18'h15555;
  end

  // Let a number of clock edges pass
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one load strobe; data scrambled once its hold has run out
  task automatic push(input logic [dcf_pkg::WIDTH-1:0] d);
    write_data <= d;
    load_clock <= 1'b1;
    hold(PH);
    load_clock <= 1'b0;
    hold(1);
    write_data <= ~d;
    hold(PH);
  endtask

  task automatic pop();
    unload_clock <= 1'b1;
    hold(PH);
    unload_clock <= 1'b0;
    hold(PH);
  endtask

  // enable lowered while load is low, then two edges
  task automatic set_offsets(input logic [4:0] x, input logic [4:0] y);
    offset_program_enable_n <= 1'b0;
    hold(PH);
    push({13'h0000, x});
    push({13'h0000, y});
    offset_program_enable_n <= 1'b1;
    hold(PH);
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the dual-clock word buffer
`timescale 1ns/10ps
module tb_top;
  // Table row: stored count and flags full_n, empty_n, half, almost
  typedef struct {
    int cnt;
    logic [3:0] flg;
  } dcf_row_t;
  // Offsets programmed to 3 and 5 before these rows run
  dcf_row_t rows [10] = '{'{0, 4'h9}, '{1, 4'hD}, '{3, 4'hD},
    '{4, 4'hC}, '{31, 4'hC}, '{32, 4'hE}, '{58, 4'hE}, '{59, 4'hF},
    '{63, 4'hF}, '{64, 4'h7}};
  logic mclk, rst_n, output_disable, psel, penable, pwrite, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, read_data_oe_n, load_clock, unload_clock;
  logic offset_program_enable_n, full_n, empty_n, half_full_flag;
  logic almost_flag;
  logic [dcf_pkg::WIDTH-1:0] write_data, read_data;
  int n_mismatch = 0, checks_done = 0, cyc = 0, n_in = 0, n_out = 0;
  // Board view of the read port; floats when disabled
  wire [dcf_pkg::WIDTH-1:0] q_pin = read_data_oe_n ? 'z : read_data;
  wire [3:0] flg = {full_n, empty_n, half_full_flag, almost_flag};

  // Free-running system clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  dcf_far_model u_far (.mclk(mclk), .load_clock(load_clock),
    .unload_clock(unload_clock), .write_data(write_data),
    .offset_program_enable_n(offset_program_enable_n));
  dcf_fifo dut (.mclk(mclk), .rst_n(rst_n), .load_clock(load_clock),
    .unload_clock(unload_clock), .write_data(write_data),
    .offset_program_enable_n(offset_program_enable_n),
    .output_disable(output_disable), .read_data(read_data),
    .read_data_oe_n(read_data_oe_n), .full_n(full_n),
    .empty_n(empty_n), .half_full_flag(half_full_flag),
    .almost_flag(almost_flag), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Test word touching every bit lane, both polarities
  function automatic logic [17:0] w(input int i);
    return {i[5:0], ~i[5:0], i[5:0]};
  endfunction

  // Expected status word from count, flags and written mark
  function automatic logic [31:0] st(input int c, input logic [3:0] f,
                                     input logic wr);
    return {19'h0, wr, f[0], f[1], f[2], f[3], 1'b0, c[6:0]};
  endfunction

  // Compare and count; unknowns never match
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  // APB transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Verdict and end of run
  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard; the whole run needs about 1250 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    rst_n = 1'b0;
    output_disable = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (15) @(posedge mclk);
    chk("reset flags", 4'h9, flg);
    chk("reset oe_n", 1'b1, read_data_oe_n);
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    apb(1'b0, dcf_pkg::ADDR_OFFSET, 32'h0);
    chk("default offsets", 32'h0808, rd);
    u_far.set_offsets(5'h03, 5'h05);
    apb(1'b0, dcf_pkg::ADDR_OFFSET, 32'h0);
    chk("offsets", 32'h0503, rd);
    // Fill through every flag boundary
    foreach (rows[k]) begin
      while (n_in < rows[k].cnt) begin
        u_far.push(w(n_in));
        n_in++;
      end
      chk("flags", rows[k].flg, flg);
      apb(1'b0, dcf_pkg::ADDR_STATUS, 32'h0);
      chk("status", st(n_in, rows[k].flg, n_in > 0), rd);
      if (n_in == 1) chk("first word", w(0), q_pin);
    end
    // Load while full must leave contents alone
    u_far.push(18'h3FFFF);
    apb(1'b0, dcf_pkg::ADDR_STATUS, 32'h0);
    chk("status full", st(64, 4'h7, 1'b1), rd);
    output_disable <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("port disabled", 1'b1, read_data_oe_n);
    output_disable <= 1'b0;
    repeat (4) @(posedge mclk);
    // Drain in order, rows walked backwards
    for (int k = 9; k >= 0; k--) begin
      while (n_out < 64 - rows[k].cnt) begin
        chk("word", w(n_out), q_pin);
        u_far.pop();
        n_out++;
      end
      chk("drain flags", rows[k].flg, flg);
    end
    u_far.pop();
    apb(1'b0, dcf_pkg::ADDR_STATUS, 32'h0);
    chk("status empty", st(0, 4'h9, 1'b1), rd);
    // Program attempt after a written word only loads words
    u_far.set_offsets(5'h01, 5'h02);
    apb(1'b0, dcf_pkg::ADDR_STATUS, 32'h0);
    chk("late program", st(2, 4'hD, 1'b1), rd);
    apb(1'b0, dcf_pkg::ADDR_OFFSET, 32'h0);
    chk("offsets kept", 32'h0503, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped err", 1'b1, err);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, dcf_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, dcf_pkg::ADDR_OFFSET, 32'h0);
    chk("flush offsets", 32'h0808, rd);
    apb(1'b0, dcf_pkg::ADDR_STATUS, 32'h0);
    chk("flush status", st(0, 4'h9, 1'b0), rd);
    summarize();
  end
endmodule
